// *** spicf_port.sv ***
// SPI master/slave port sharing one circular buffer for transmit and receive
//
// Contract
// - Control holds enable, master role, polarity, phase, bit order and divide select.
// - Master serial clock equals core clock divided by selected factor, e.g. 32.
// - Bytes are staged in an adjustable-depth circular buffer, not single holding registers.
// - Transmit and receive trigger levels are selected independently.
// - Readable counters give bytes waiting to send and bytes unread.
// - Transmit discard moves transmit pointer onto buffer pointer and clears transmit count.
// - Receive discard moves receive pointer onto buffer pointer and clears receive count.
// - Tx flag while count below level; rx flag when above; either raises interrupt.
// - Data write enqueues at transmit pointer; read returns oldest byte, advances pointer.
`timescale 1ns/100ps
`default_nettype none
module spicf_port
  import spicf_pkg::*;
#(
  parameter int DEPTH = SPICF_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic           core_clk,
  input  wire logic           rst_b,
  input  wire spicf_ctrl_t    serial_port_control_reg,
  input  wire logic [AW:0]    tx_trigger_level,
  input  wire logic [AW:0]    rx_trigger_level,
  input  wire logic           tx_discard_ctrl,
  input  wire logic           rx_discard_ctrl,
  input  wire logic           wr_strobe,
  input  wire logic [7:0]     wr_data,
  input  wire logic           rd_strobe,
  input  wire spicf_pin_in_t  pin_i,
  output var  logic [7:0]     serial_data_port_q,
  output var  logic           rd_valid_q,
  output var  logic [AW:0]    tx_count_q,
  output var  logic [AW:0]    rx_count_q,
  output var  logic [AW-1:0]  tx_pointer_reg_q,
  output var  logic [AW-1:0]  rx_pointer_reg_q,
  output var  logic           tx_level_flag_q,
  output var  logic           rx_level_flag_q,
  output var  logic           shared_power_fail_irq_q,
  output var  spicf_pin_out_t pin_o_q
);
  localparam int          CW   = AW + 1;
  localparam logic [AW:0] FULL = CW'(DEPTH);

  function automatic logic [7:0] spicf_rev(input logic [7:0] b);
    spicf_rev = {<<{b}};
  endfunction : spicf_rev

  spicf_ctrl_t     cfg;
  spicf_state_t    state_q;
  logic [7:0]      mem [DEPTH];
  logic [AW-1:0]   fifo_ptr_q, fifo_ptr_d, tx_ptr_d, rx_ptr_d;
  logic [AW:0]     tx_cnt_d, rx_cnt_d, occ;
  logic [6:0]      div_cnt_q, half_m1;
  logic [3:0]      half_q, bit_cnt_q;
  logic [7:0]      tx_sh_q, rx_sh_q, rx_next;
  logic            sclk_prev_q, ss_prev_q;
  logic            run, tick, sel, edge_s, lead, trail, sample, shift, sin;
  logic            done, start, ss_fall, st_ok, tx_dec, wr_ok, rd_ok;

  assign cfg = serial_port_control_reg;
  assign run = (state_q == SPICF_RUN);
  assign occ = tx_count_q + rx_count_q;

  // ----------------------------------------------------------------------
  // Clock divider and edge events
  // ----------------------------------------------------------------------
  // Half period is 1 << div_sel cycles, so a full period is 2 << div_sel
  assign half_m1 = 7'((8'h01 << cfg.div_sel) - 8'h01);
  assign tick    = run && (div_cnt_q == half_m1);
  assign start   = (state_q == SPICF_IDLE) && cfg.port_enable_bit && cfg.master_role_bit && (tx_count_q != '0);

  // Slave events come from pin edges; pins are synchronous to core_clk
  assign sel     = cfg.port_enable_bit && !cfg.master_role_bit && !pin_i.ss_b;
  assign edge_s  = sel && (pin_i.sclk != sclk_prev_q);
  assign ss_fall = sel && ss_prev_q;
  assign lead    = cfg.master_role_bit ? (tick && !half_q[0]) : (edge_s && (pin_i.sclk != cfg.cpol));
  assign trail   = cfg.master_role_bit ? (tick && half_q[0]) : (edge_s && (pin_i.sclk == cfg.cpol));
  // Phase picks which edge samples; first shift is skipped so bit 7 is seen first
  assign sample  = cfg.cpha ? trail : lead;
  assign shift   = (cfg.cpha ? lead : trail) && (bit_cnt_q != '0);
  assign sin     = cfg.master_role_bit ? pin_i.miso : pin_i.mosi;
  assign rx_next = sample ? {rx_sh_q[6:0], sin} : rx_sh_q;
  assign done    = cfg.master_role_bit ? (tick && half_q == SPICF_LAST_HALF)
                                       : (sample && bit_cnt_q == SPICF_LAST_BIT);

  // ----------------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= SPICF_IDLE;
      div_cnt_q <= SPICF_DIV_RST;
      half_q    <= '0;
    end else begin
      unique case (state_q)
        SPICF_IDLE: begin
          div_cnt_q <= SPICF_DIV_RST;
          half_q    <= '0;
          if (start) begin
            state_q <= SPICF_RUN;
          end
        end
        SPICF_RUN: begin
          div_cnt_q <= tick ? SPICF_DIV_RST : div_cnt_q + 7'h01;
          if (tick) begin
            half_q <= half_q + 4'h1;
          end
          // Dropping enable aborts the byte; nothing is stored
          if (done || !cfg.port_enable_bit || !cfg.master_role_bit) begin
            state_q <= SPICF_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Shift registers: full duplex, always MSB-first inside
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh_q     <= SPICF_DATA_RST;
      rx_sh_q     <= SPICF_DATA_RST;
      bit_cnt_q   <= '0;
      sclk_prev_q <= 1'b0;
      ss_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= pin_i.sclk;
      ss_prev_q   <= pin_i.ss_b;
      if (start || ss_fall) begin
        tx_sh_q   <= cfg.lsb_first ? spicf_rev(mem[fifo_ptr_q]) : mem[fifo_ptr_q];
        bit_cnt_q <= '0;
      end else if (done && sel) begin
        // Slave keeps going while select stays low
        tx_sh_q   <= cfg.lsb_first ? spicf_rev(mem[fifo_ptr_d]) : mem[fifo_ptr_d];
        bit_cnt_q <= '0;
      end else begin
        if (shift) begin
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
        if (done) begin
          bit_cnt_q <= '0;
        end else if (sample) begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
      rx_sh_q <= rx_next;
    end
  end

  // ----------------------------------------------------------------------
  // Circular buffer bookkeeping
  // ----------------------------------------------------------------------
  // Received byte lands in the slot its transmit byte just left
  assign st_ok      = done && ((tx_count_q != '0) || (occ < FULL));
  assign tx_dec     = st_ok && (tx_count_q != '0);
  assign fifo_ptr_d = fifo_ptr_q + AW'(st_ok);
  // A write may not race a slave store into the same empty slot
  assign wr_ok      = wr_strobe && (occ < FULL) && !tx_discard_ctrl && !(st_ok && tx_count_q == '0);
  assign rd_ok      = rd_strobe && (rx_count_q != '0) && !rx_discard_ctrl;
  assign tx_cnt_d   = tx_discard_ctrl ? '0 : tx_count_q + CW'(wr_ok) - CW'(tx_dec);
  assign tx_ptr_d   = tx_discard_ctrl ? fifo_ptr_d
                    : tx_pointer_reg_q + AW'(wr_ok) + AW'(st_ok && tx_count_q == '0);
  assign rx_cnt_d   = rx_discard_ctrl ? '0 : rx_count_q + CW'(st_ok) - CW'(rd_ok);
  assign rx_ptr_d   = rx_discard_ctrl ? fifo_ptr_d : rx_pointer_reg_q + AW'(rd_ok);

  // Pointer and counter registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_ptr_q       <= '0;
      tx_pointer_reg_q <= '0;
      rx_pointer_reg_q <= '0;
      tx_count_q       <= '0;
      rx_count_q       <= '0;
    end else begin
      fifo_ptr_q       <= fifo_ptr_d;
      tx_pointer_reg_q <= tx_ptr_d;
      rx_pointer_reg_q <= rx_ptr_d;
      tx_count_q       <= tx_cnt_d;
      rx_count_q       <= rx_cnt_d;
    end
  end

  // Buffer storage; no reset so it maps onto RAM
  always_ff @(posedge core_clk) begin
    if (wr_ok) begin
      mem[tx_pointer_reg_q] <= wr_data;
    end
    if (st_ok) begin
      mem[fifo_ptr_q] <= cfg.lsb_first ? spicf_rev(rx_next) : rx_next;
    end
  end

  // Read port; a read of an empty receive side is ignored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_port_q <= SPICF_DATA_RST;
      rd_valid_q         <= 1'b0;
    end else begin
      rd_valid_q <= rd_ok;
      if (rd_ok) begin
        serial_data_port_q <= mem[rx_pointer_reg_q];
      end
    end
  end

  // Level flags follow the next counts so they agree with the counters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_level_flag_q         <= 1'b0;
      rx_level_flag_q         <= 1'b0;
      shared_power_fail_irq_q <= 1'b0;
    end else begin
      tx_level_flag_q         <= tx_cnt_d < tx_trigger_level;
      rx_level_flag_q         <= rx_cnt_d > rx_trigger_level;
      shared_power_fail_irq_q <= (tx_cnt_d < tx_trigger_level) || (rx_cnt_d > rx_trigger_level);
    end
  end

  // Pins, registered; one cycle later than the internal events
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_o_q <= '{ss_b_o: 1'b1, default: 1'b0};
    end else begin
      pin_o_q.sclk_o  <= cfg.cpol ^ (run && half_q[0]);
      pin_o_q.sclk_oe <= cfg.port_enable_bit && cfg.master_role_bit;
      pin_o_q.mosi_o  <= tx_sh_q[7];
      pin_o_q.mosi_oe <= cfg.port_enable_bit && cfg.master_role_bit;
      pin_o_q.miso_o  <= tx_sh_q[7];
      pin_o_q.miso_oe <= sel;
      pin_o_q.ss_b_o  <= !run;
      pin_o_q.ss_b_oe <= cfg.port_enable_bit && cfg.master_role_bit;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [6:0] gap_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= '0;
    end else begin
      gap_q <= (!run || tick) ? 7'h00 : gap_q + 7'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  clk_divide_a: assert property (tick && half_q != '0 |-> gap_q == half_m1)
    else $error("Serial clock half period wrong");
  // Next tick is due sixteen cycles on; the last tick of a byte has no successor
  div32_a: assert property (run && cfg.div_sel == SPICF_DIV32_SEL && tick && !done
                            |=> !tick ##14 !tick ##1 tick)
    else $error("Divide by 32 half period wrong");
  buf_bound_a: assert property (tx_count_q + rx_count_q <= FULL)
    else $error("Buffer occupancy exceeds depth");
  tx_flush_a: assert property (tx_discard_ctrl |=> tx_count_q == '0 && tx_pointer_reg_q == fifo_ptr_q)
    else $error("Transmit discard failed");
  rx_flush_a: assert property (rx_discard_ctrl |=> rx_count_q == '0 && rx_pointer_reg_q == fifo_ptr_q)
    else $error("Receive discard failed");
  tx_flag_a: assert property (1'b1 |=> tx_level_flag_q == (tx_count_q < $past(tx_trigger_level)))
    else $error("Transmit flag disagrees with count");
  irq_join_a: assert property (shared_power_fail_irq_q == (tx_level_flag_q || rx_level_flag_q))
    else $error("Interrupt not the OR of flags");
  wr_enq_a: assert property (wr_strobe && occ < FULL && !tx_discard_ctrl && !done
                             |=> tx_count_q == $past(tx_count_q) + 1'b1)
    else $error("Write did not enqueue");
  rd_deq_a: assert property (rd_strobe && rx_count_q != '0 && !rx_discard_ctrl && !done
                             |=> rd_valid_q && rx_count_q == $past(rx_count_q) - 1'b1)
    else $error("Read did not dequeue");
  byte_len_a: assert property (done && cfg.master_role_bit |-> bit_cnt_q == SPICF_FULL_BITS
                               || (sample && bit_cnt_q == SPICF_LAST_BIT))
    else $error("Byte done without eight samples");

  master_byte_c: cover property (done && cfg.master_role_bit && st_ok);
  slave_byte_c:  cover property (done && !cfg.master_role_bit && st_ok);
  buf_full_c:    cover property (occ == FULL);
endmodule : spicf_port
`default_nettype wire

// *** spicf_pkg.sv ***
// Package: constants and carriers for the SPI port with circular buffer
`default_nettype none
package spicf_pkg;
  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int         SPICF_DEPTH    = 16;    // Bytes in the circular buffer
  localparam int         SPICF_BITS     = 8;     // Bits per transfer
  localparam logic [3:0] SPICF_LAST_HALF = 4'hf; // Last of 16 clock half periods
  localparam logic [3:0] SPICF_LAST_BIT  = 4'h7; // Index of eighth sample
  localparam logic [3:0] SPICF_FULL_BITS = 4'h8; // Samples in one byte
  localparam logic [7:0] SPICF_DATA_RST  = 8'h00;
  localparam logic [6:0] SPICF_DIV_RST   = 7'h00;

  // Master clock runs at core_clk / (2 << div_sel); 3'h4 gives one thirty-second
  localparam logic [2:0] SPICF_DIV32_SEL = 3'h4;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       port_enable_bit;
    logic       master_role_bit;
    logic       cpol;
    logic       cpha;
    logic       lsb_first;
    logic [2:0] div_sel;
  } spicf_ctrl_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_b;
  } spicf_pin_in_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_b_o;
    logic ss_b_oe;
  } spicf_pin_out_t;

  typedef enum logic [1:0] {
    SPICF_IDLE = 2'b01,
    SPICF_RUN  = 2'b10
  } spicf_state_t;
endpackage : spicf_pkg
`default_nettype wire

// *** spicf_slave_model.sv ***
// Behavioural SPI slave standing on the far side of the port, mode 0, MSB first
`timescale 1ns/100ps
`default_nettype none
module spicf_slave_model (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_b,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  // ----------------------------------------------------------------------
  // Shift logic
  // ----------------------------------------------------------------------
  logic [7:0] shift_q;

  initial begin
    miso    = 1'b0;
    rx_byte = 8'h00;
    shift_q = 8'h00;
  end

  // Select loads a fresh byte and puts its first bit out at once
  always @(negedge ss_b) begin
    shift_q = tx_byte;
    miso    = tx_byte[7];
  end

  // Leading edge samples, trailing edge shifts, so in and out move together
  always @(posedge sclk) begin
    if (!ss_b) rx_byte = {rx_byte[6:0], mosi};
  end

  always @(negedge sclk) begin
    if (!ss_b) begin
      shift_q = {shift_q[6:0], 1'b0};
      miso    = shift_q[7];
    end
  end

  // Released line must not keep its last bit, or a stale sample would pass
  always @(posedge ss_b) begin
    miso = ~miso;
  end
endmodule : spicf_slave_model
`default_nettype wire

// *** spicf_port_tb_top.sv ***
// Self-checking bench for the SPI port with circular buffer
`timescale 1ns/100ps
`default_nettype none
module spicf_port_tb_top;
  import spicf_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic           core_clk = 1'b0;
  logic           rst_b = 1'b0;
  spicf_ctrl_t    ctrl = spicf_ctrl_t'(8'h00);
  logic [4:0]     tx_lvl = 5'h04;
  logic [4:0]     rx_lvl = 5'h02;
  logic           tx_dis = 1'b0;
  logic           rx_dis = 1'b0;
  logic           wr_stb = 1'b0;
  logic [7:0]     wr_dat = 8'h00;
  logic           rd_stb = 1'b0;
  spicf_pin_in_t  pin_i;
  spicf_pin_out_t pin_o;
  logic [7:0]     rd_dat, slv_rx;
  logic           rd_vld, tx_flag, rx_flag, irq, slv_miso;
  logic [4:0]     tx_cnt, rx_cnt;
  logic [3:0]     tx_ptr, rx_ptr;
  logic [7:0]     got[$];
  logic           m_sclk = 1'b0;
  logic           m_mosi = 1'b0;
  logic           m_ss_b = 1'b1;
  logic [7:0]     m_rx;
  int             err_total = 0;
  int             checks = 0;
  int             cyc = 0;
  int             n;

  always #4 core_clk = ~core_clk;

  // Wire levels: undriven pins come from the bench; its idle select stands for the pull-up
  assign pin_i = '{sclk: pin_o.sclk_oe ? pin_o.sclk_o : m_sclk, mosi: pin_o.mosi_oe ? pin_o.mosi_o : m_mosi,
                   miso: slv_miso, ss_b: pin_o.ss_b_oe ? pin_o.ss_b_o : m_ss_b};

  spicf_port dut (.core_clk(core_clk), .rst_b(rst_b), .serial_port_control_reg(ctrl),
    .tx_trigger_level(tx_lvl), .rx_trigger_level(rx_lvl), .tx_discard_ctrl(tx_dis),
    .rx_discard_ctrl(rx_dis), .wr_strobe(wr_stb), .wr_data(wr_dat), .rd_strobe(rd_stb),
    .pin_i(pin_i), .serial_data_port_q(rd_dat), .rd_valid_q(rd_vld), .tx_count_q(tx_cnt),
    .rx_count_q(rx_cnt), .tx_pointer_reg_q(tx_ptr), .rx_pointer_reg_q(rx_ptr),
    .tx_level_flag_q(tx_flag), .rx_level_flag_q(rx_flag), .shared_power_fail_irq_q(irq),
    .pin_o_q(pin_o));

  spicf_slave_model slave (.sclk(pin_i.sclk), .mosi(pin_i.mosi), .ss_b(pin_i.ss_b),
    .tx_byte(8'h96), .miso(slv_miso), .rx_byte(slv_rx));

  // Each finished byte as the slave saw it
  always @(posedge pin_o.ss_b_o) begin
    if (rst_b && ctrl.port_enable_bit) got.push_back(slv_rx);
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Hang guard well above the two 256-cycle bytes
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask : chk

  task automatic wr_byte(input logic [7:0] d);
    @(negedge core_clk);
    wr_stb = 1'b1;
    wr_dat = d;
    @(negedge core_clk);
    wr_stb = 1'b0;
  endtask : wr_byte

  // Read data is due one cycle after the strobe edge
  task automatic rd_byte(input logic [7:0] exp_v);
    @(negedge core_clk);
    rd_stb = 1'b1;
    @(negedge core_clk);
    rd_stb = 1'b0;
    chk({7'h0, rd_vld}, 8'h01);
    chk(rd_dat, exp_v);
  endtask : rd_byte

  // Bench as link master with phase 1: drive on leading edge, sample on trailing, MSB first
  task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(negedge core_clk);
    m_ss_b = 1'b0;
    repeat (4) @(negedge core_clk);
    chk({7'h0, pin_o.miso_oe}, 8'h01);
    for (i = 7; i >= 0; i--) begin
      m_sclk = ~ctrl.cpol;
      m_mosi = tx[i];
      repeat (4) @(negedge core_clk);
      m_sclk = ctrl.cpol;
      rx     = {rx[6:0], pin_o.miso_o};
      repeat (4) @(negedge core_clk);
    end
    m_ss_b = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask : spi_xfer

  // Cycles from one rising serial clock to the next, bounded
  task automatic sclk_period(output int cnt);
    int i;
    cnt = 0;
    for (i = 0; i < 1000 && !(pin_o.sclk_o === 1'b0); i++) @(negedge core_clk);
    for (i = 0; i < 1000 && !(pin_o.sclk_o === 1'b1); i++) @(negedge core_clk);
    for (i = 0; i < 1000 && !(pin_o.sclk_o === 1'b0); i++) begin
      @(negedge core_clk);
      cnt++;
    end
    for (i = 0; i < 1000 && !(pin_o.sclk_o === 1'b1); i++) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask : sclk_period

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    chk({3'h0, tx_cnt}, 8'h00);
    chk({7'h0, tx_flag}, 8'h01);
    chk({7'h0, irq}, 8'h01);
    // Queue four bytes while the port is off; flag drops at the level
    repeat (3) wr_byte(8'h11);
    chk({3'h0, tx_cnt}, 8'h03);
    chk({4'h0, tx_ptr}, 8'h03);
    chk({7'h0, tx_flag}, 8'h01);
    wr_byte(8'h22);
    chk({7'h0, tx_flag}, 8'h00);
    chk({7'h0, rx_flag | irq}, 8'h00);
    // Discard the queue: pointer returns to the unsent slot 0
    @(negedge core_clk);
    tx_dis = 1'b1;
    @(negedge core_clk);
    tx_dis = 1'b0;
    chk({3'h0, tx_cnt}, 8'h00);
    chk({4'h0, tx_ptr}, 8'h00);
    // Two bytes out as master at one thirty-second of the core clock
    wr_byte(8'ha5);
    wr_byte(8'h3c);
    rx_lvl = 5'h01;
    ctrl = spicf_ctrl_t'({5'b11000, SPICF_DIV32_SEL});
    sclk_period(n);
    chk(n[7:0], 8'h20);
    for (n = 0; n < 2000 && !(rx_cnt === 5'h02); n++) @(negedge core_clk);
    repeat (40) @(negedge core_clk);
    ctrl = spicf_ctrl_t'(8'h00);
    chk({3'h0, tx_cnt}, 8'h00);
    chk({3'h0, rx_cnt}, 8'h02);
    chk({7'h0, rx_flag}, 8'h01);
    chk(8'(got.size()), 8'h02);
    if (got.size() == 2) begin
      chk(got[0], 8'ha5);
      chk(got[1], 8'h3c);
    end
    // Read the oldest byte, then discard the other unread one
    rd_byte(8'h96);
    chk({3'h0, rx_cnt}, 8'h01);
    chk({4'h0, rx_ptr}, 8'h01);
    @(negedge core_clk);
    rx_dis = 1'b1;
    @(negedge core_clk);
    rx_dis = 1'b0;
    chk({3'h0, rx_cnt}, 8'h00);
    chk({4'h0, rx_ptr}, 8'h02);
    chk({7'h0, rx_flag}, 8'h00);
    // Slave role, polarity 1, phase 1, LSB first: one byte each way
    wr_byte(8'h12);
    m_sclk = 1'b1;
    ctrl = spicf_ctrl_t'({5'b10111, 3'h0});
    spi_xfer(8'h35, m_rx);
    chk(m_rx, 8'h48);
    chk({3'h0, tx_cnt}, 8'h00);
    chk({3'h0, rx_cnt}, 8'h01);
    ctrl = spicf_ctrl_t'(8'h00);
    rd_byte(8'hac);
    complete_run();
  end
endmodule : spicf_port_tb_top
`default_nettype wire
